/* lsbc_pkg.sv */
// Package for the display supply and blink control block
package lsbc_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_SUPPLY = 4'h0;
  localparam logic [3:0] ADDR_BLINK  = 4'h4;
  localparam logic [3:0] ADDR_DUTY   = 4'h8;
  // Reset values
  localparam logic [7:0] RST_SUPPLY = 8'h00;
  localparam logic [7:0] RST_BLINK  = 8'h00;
  localparam logic [2:0] RST_DUTY   = 3'h3;
  // Supply register fields
  localparam int SUP_SRC_BIT = 7;
  localparam int SUP_LOAD_ADJUST_LO = 4;
  localparam int SUP_VS_LO   = 0;
  localparam logic [7:0] SUP_WMASK = 8'hB3;
  // Blink register fields
  localparam int BLK_EN_BIT    = 7;
  localparam int BLK_ALT_BIT   = 6;
  localparam int BLK_BLANK_BIT = 5;
  localparam int BLK_MODE_BIT  = 3;
  localparam int BLK_RATE_LO   = 0;
  localparam logic [7:0] BLK_WMASK = 8'hEF;
  // Duty register: driver enable at bit 7, duty in 2:0
  localparam int DUTY_EN_BIT = 7;
  localparam logic [2:0] DUTY_MAX_ALT = 3'h3;
  // Blink divider: exponent base and counter width
  localparam int BLINK_EXP_BASE = 12;
  localparam int BLINK_CNT_W    = 20;
  // Pump clock dividers per load code
  localparam logic [3:0] PUMP_DIV0 = 4'h1;
  localparam logic [3:0] PUMP_DIV1 = 4'h2;
  localparam logic [3:0] PUMP_DIV2 = 4'h4;
  localparam logic [3:0] PUMP_DIV3 = 4'h8;
  // Bias ratio is fixed at one third
  localparam logic [1:0] BIAS_DEN = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Supply modes
  typedef enum logic [1:0] {
    SUP_MID_INT = 2'h0,
    SUP_TOP_INT = 2'h1,
    SUP_RSVD    = 2'h2,
    SUP_TOP_EXT = 2'h3
  } lsbc_supply_t;
endpackage

/* lsbc_blink_timer.sv */
// Free-running blink divider producing the blink phase
`timescale 1ns/1ps
module lsbc_blink_timer
  import lsbc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clkEn,
  // Rate and phase
  input  wire logic [2:0] rate,
  output logic            phase
);
  import lsbc_pkg::*;

  logic [BLINK_CNT_W-1:0] count;

  // Free running counter, display clock rate
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count <= '0;
    end else if (clkEn) begin
      count <= count + 1'b1;
    end
  end

  // Bit (11+rate) toggles every 2^(11+rate): period 2^(12+rate), equal halves
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase <= 1'b0;
    end else if (clkEn) begin
      phase <= count[BLINK_EXP_BASE - 1 + int'(rate)];
    end
  end
endmodule // lsbc_blink_timer

/* lsbc_pump_clock.sv */
// Charge pump clock divider selected by load adjust
`timescale 1ns/1ps
module lsbc_pump_clock
  import lsbc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clkEn,
  // Control and output
  input  wire logic       enable,
  input  wire logic [1:0] loadAdjust,
  output logic            pumpClk
);
  import lsbc_pkg::*;

  logic [3:0] divCount;
  logic [3:0] divLimit;

  // Faster codes use smaller dividers
  always_comb begin
    unique case (loadAdjust)
      2'h0: divLimit = PUMP_DIV0;
      2'h1: divLimit = PUMP_DIV1;
      2'h2: divLimit = PUMP_DIV2;
      2'h3: divLimit = PUMP_DIV3;
    endcase
  end

  // Toggle pump clock; held low while pump disabled
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      divCount <= '0;
      pumpClk  <= 1'b0;
    end else if (clkEn) begin
      if (!enable) begin
        // Parked inside the enable so a frozen clock keeps the divider as it was
        divCount <= '0;
        pumpClk  <= 1'b0;
      end else if (divCount + 4'h1 >= divLimit) begin
        divCount <= '0;
        pumpClk  <= ~pumpClk;
      end else begin
        divCount <= divCount + 4'h1;
      end
    end
  end
endmodule // lsbc_pump_clock

/* lsbc_top.sv */
// Display supply and blink control with AXI4-Lite registers
//
// How it works
// - Bit 7 picks pump or resistor ladder.
// - Bias is always one third.
// - Load adjust sets pump clock rate.
// - Ladder codes 0-1 low, 2-3 high load.
// - Supply field selects three supply modes; code 2 is reserved.
// - All three registers readable and writable anytime.
// - Blink bit 7 starts and stops blinking.
// - Blink rate is clock over 2^(12+rate).
// - Alternate display only up to four backplanes.
// - Blank bit turns every segment off.
// - Bit 3 picks blank or alternate blink.
// - Duty value n uses n+1 backplanes.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module lsbc_top
  import lsbc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clkEn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Supply network controls
  output logic             pumpEnable,
  output logic             ladderEnable,
  output logic             ladderHighLoad,
  output logic             pumpClk,
  output logic [1:0]       biasDenominator,
  output logic             glassMiddleLevelInternal,
  output logic             glassTopLevelInternal,
  output logic             glassTopLevelExternal,
  // Sequencer display selection
  output logic [3:0]       backplaneCount,
  output logic             showAlternate,
  output logic             showBlank,
  output logic             blinkPhase
);
  import lsbc_pkg::*;

  logic [7:0] displaySupplyConfig;
  logic [7:0] displayBlinkControl;
  logic [7:0] displayDutyConfig;
  logic       awHeld;
  logic       wHeld;
  logic [3:0] awAddr;
  logic [7:0] wByte;
  logic       wLane0;
  logic       phase;

  // Map decode, used by both read and write paths
  function automatic logic addrMapped(input logic [3:0] a);
    return a == ADDR_SUPPLY || a == ADDR_BLINK || a == ADDR_DUTY;
  endfunction

  // Alternate display only allowed with four or fewer backplanes
  function automatic logic altAllowed(input logic [2:0] duty);
    return duty <= DUTY_MAX_ALT;
  endfunction

  // Ready while the holding slot is empty and no response pending
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Capture write address and data in either order
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= '0;
      wByte  <= '0;
      wLane0 <= 1'b0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (awHeld && wHeld) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld  <= 1'b1;
        wByte  <= s_axi_wdata[7:0];
        wLane0 <= s_axi_wstrb[0];
      end else if (awHeld && wHeld) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Register writes: no state gating, accepted at any time
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      displaySupplyConfig <= RST_SUPPLY;
      displayBlinkControl <= RST_BLINK;
      displayDutyConfig   <= {5'h00, RST_DUTY};
    end else if (clkEn && awHeld && wHeld && wLane0) begin
      unique case (awAddr)
        ADDR_SUPPLY: displaySupplyConfig <= wByte & SUP_WMASK;
        ADDR_BLINK:  displayBlinkControl <= wByte & BLK_WMASK;
        ADDR_DUTY:   displayDutyConfig   <= wByte & 8'h87;
        default: ;
      endcase
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (awHeld && wHeld) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addrMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data registered one cycle after the address
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addrMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        unique case (s_axi_araddr)
          ADDR_SUPPLY: s_axi_rdata <= {24'h00_0000, displaySupplyConfig};
          ADDR_BLINK:  s_axi_rdata <= {24'h00_0000, displayBlinkControl};
          ADDR_DUTY:   s_axi_rdata <= {24'h00_0000, displayDutyConfig};
          default:     s_axi_rdata <= '0;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Bias source and load decode
  logic       pumpSel;
  logic [1:0] loadAdj;
  logic [1:0] supplyCtl;
  logic [2:0] duty;
  assign pumpSel   = displaySupplyConfig[SUP_SRC_BIT];
  assign loadAdj   = displaySupplyConfig[SUP_LOAD_ADJUST_LO +: 2];
  assign supplyCtl = displaySupplyConfig[SUP_VS_LO +: 2];
  assign duty      = displayDutyConfig[2:0];

  // Supply outputs registered; software keeps supply field stable when enabled
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pumpEnable               <= 1'b0;
      ladderEnable             <= 1'b0;
      ladderHighLoad           <= 1'b0;
      biasDenominator          <= BIAS_DEN;
      glassMiddleLevelInternal <= 1'b0;
      glassTopLevelInternal    <= 1'b0;
      glassTopLevelExternal    <= 1'b0;
      backplaneCount           <= 4'h0;
    end else if (clkEn) begin
      pumpEnable      <= pumpSel;
      ladderEnable    <= !pumpSel;
      ladderHighLoad  <= !pumpSel && loadAdj[1];
      biasDenominator <= BIAS_DEN;
      // Reserved code drives nothing; leaves the match to software
      glassMiddleLevelInternal <= supplyCtl == SUP_MID_INT;
      glassTopLevelInternal    <= supplyCtl == SUP_TOP_INT;
      glassTopLevelExternal    <= supplyCtl == SUP_TOP_EXT;
      backplaneCount <= {1'b0, duty} + 4'h1;
    end
  end

  // Blink divider
  lsbc_blink_timer u_blink (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .rate    (displayBlinkControl[BLK_RATE_LO +: 3]),
    .phase   (phase)
  );

  // Pump clock, only runs while the pump is selected
  lsbc_pump_clock u_pump (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .clkEn      (clkEn),
    .enable     (pumpSel),
    .loadAdjust (loadAdj),
    .pumpClk    (pumpClk)
  );

  // Display selection: blank wins, then blink period, then alternate
  logic blinkOn;
  logic inBlinkPeriod;
  logic next_showAlternate;
  logic next_showBlank;
  assign blinkOn       = displayBlinkControl[BLK_EN_BIT];
  assign inBlinkPeriod = blinkOn && phase;
  always_comb begin
    next_showBlank     = 1'b0;
    next_showAlternate = 1'b0;
    if (displayBlinkControl[BLK_BLANK_BIT]) begin
      next_showBlank = 1'b1;
    end else if (inBlinkPeriod) begin
      if (displayBlinkControl[BLK_MODE_BIT] && altAllowed(duty)) begin
        next_showAlternate = 1'b1;
      end else begin
        next_showBlank = 1'b1;
      end
    end else begin
      next_showAlternate = displayBlinkControl[BLK_ALT_BIT] && altAllowed(duty);
    end
  end

  // Registered display selection outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      showBlank     <= 1'b0;
      showAlternate <= 1'b0;
      blinkPhase    <= 1'b0;
    end else if (clkEn) begin
      showBlank     <= next_showBlank;
      showAlternate <= next_showAlternate;
      blinkPhase    <= inBlinkPeriod;
    end
  end

  // Checks
  sequence blinkWrite_s;
    clkEn && awHeld && wHeld && wLane0 && awAddr == ADDR_BLINK;
  endsequence

  pump_select_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn |=> (pumpEnable == $past(pumpSel)) && (ladderEnable != pumpEnable))
    else $error("bias source outputs wrong");
  bias_third_a: assert property (@(posedge clk_sys) disable iff (reset)
    biasDenominator == 2'h3)
    else $error("bias not one third");
  ladder_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && !pumpSel |=> ladderHighLoad == $past(loadAdj[1]))
    else $error("ladder load wrong");
  supply_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && supplyCtl == 2'h2 |=> !glassMiddleLevelInternal && !glassTopLevelInternal
      && !glassTopLevelExternal)
    else $error("reserved supply drives a level");
  blink_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    blinkWrite_s |=> displayBlinkControl == ($past(wByte) & BLK_WMASK))
    else $error("blink register write lost");
  blink_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && !blinkOn |=> !blinkPhase)
    else $error("blink phase while disabled");
  alt_duty_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && duty > 3'h3 |=> !showAlternate)
    else $error("alternate shown with many backplanes");
  blank_all_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && displayBlinkControl[BLK_BLANK_BIT] |=> showBlank && !showAlternate)
    else $error("blank not shown");
  backplane_count_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn |=> backplaneCount == {1'b0, $past(duty)} + 4'h1)
    else $error("backplane count wrong");
  pump_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && !pumpSel |=> !pumpClk)
    else $error("pump clock runs while ladder selected");
  blink_alt_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && inBlinkPeriod && !displayBlinkControl[BLK_BLANK_BIT]
      && displayBlinkControl[BLK_MODE_BIT] && duty <= 3'h3 |=> showAlternate && !showBlank)
    else $error("alternate not shown in blink period");
  blink_blank_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && inBlinkPeriod && duty > 3'h3 |=> showBlank && !showAlternate)
    else $error("blink period not blank with many backplanes");
  resp_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  read_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule // lsbc_top

/* lsbc_glass_model.sv */
// Glass and supply network model that times the charge pump clock
`timescale 1ns/1ps
module lsbc_glass_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Pump clock seen by the glass supply
  input  wire logic       pumpClk,
  // Measured pump half period in clock cycles
  output logic [7:0]      halfPeriod
);
  logic [7:0] run;
  logic       lastClk;

  // Cycles between pump edges; the glass only loads on edges
  always_ff @(posedge clk_sys) begin
    lastClk <= pumpClk;
    if (reset || pumpClk != lastClk) begin
      run <= 8'h01;
    end else begin
      run <= run + 8'h01;
    end
    if (reset) begin
      halfPeriod <= 8'h00;
    end else if (pumpClk != lastClk) begin
      halfPeriod <= run;
    end
  end
endmodule // lsbc_glass_model

/* tb_top.sv */
// Self-checking bench for the display supply and blink control block
`timescale 1ns/1ps
module tb_top;
  import lsbc_pkg::*;
  logic        clk_sys, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, watchAlt, watched;
  logic [3:0]  awaddr, araddr, bpCount;
  logic [31:0] wdata, rdata, rd, d;
  logic [1:0]  bresp, rresp, rsp, biasDen;
  logic        pumpEn, ladderEn, ladderHigh, pumpClk, midInt, topInt, topExt;
  logic        showAlt, showBlank, blinkPhase, clkEn;
  logic [7:0]  halfPeriod;
  logic [4:0]  s;
  int          failures = 0, num_checks = 0, seed = 12, h, i;

  lsbc_top i_lsbc_top (
    .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .pumpEnable(pumpEn),
    .ladderEnable(ladderEn), .ladderHighLoad(ladderHigh), .pumpClk(pumpClk),
    .biasDenominator(biasDen), .glassMiddleLevelInternal(midInt),
    .glassTopLevelInternal(topInt), .glassTopLevelExternal(topExt),
    .backplaneCount(bpCount), .showAlternate(showAlt), .showBlank(showBlank),
    .blinkPhase(blinkPhase)
  );

  lsbc_glass_model i_lsbc_glass_model (
    .clk_sys(clk_sys), .reset(reset), .pumpClk(pumpClk), .halfPeriod(halfPeriod)
  );

  // Display output whose toggling is being timed
  assign watched = watchAlt ? showAlt : showBlank;

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Write holds each channel until its own ready, then waits for the response
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic rdr(input logic [3:0] a);
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // Cycles between two toggles; 10000 means it never toggled
  task automatic half(input logic alternate_display, output int n);
    logic v;
    watchAlt = alternate_display;
    @(posedge clk_sys);
    for (int r = 0; r < 2; r++) begin
      v = watched;
      n = 0;
      while (watched === v && n < 10000) begin
        @(posedge clk_sys);
        n++;
      end
    end
  endtask

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, watchAlt} = '0;
    clkEn = 1'b1;
    {awaddr, araddr, wdata} = '0;
    reset = 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(32'(biasDen), 32'h3);
    check(32'(bpCount), 32'h4);
    rdr(ADDR_SUPPLY);
    check(rd, 32'(RST_SUPPLY));
    rdr(ADDR_BLINK);
    check(rd, 32'(RST_BLINK));
    rdr(ADDR_DUTY);
    check(rd, 32'(RST_DUTY));
    // Unmapped slot is refused both ways
    wr(4'hC, 32'h0000_00FF);
    check(32'(rsp), 32'(RESP_SLVERR));
    rdr(4'hC);
    check({rd[29:0], rsp}, 32'(RESP_SLVERR));
    // Random readback; driver enable stays clear meanwhile
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(ADDR_SUPPLY, d);
      check(32'(rsp), 32'(RESP_OKAY));
      rdr(ADDR_SUPPLY);
      check(rd, d & 32'(SUP_WMASK));
      d = $random(seed);
      wr(ADDR_BLINK, d);
      rdr(ADDR_BLINK);
      check(rd, d & 32'(BLK_WMASK));
    end
    // Every source, load code and supply mode
    for (i = 0; i < 32; i++) begin
      s = i[4:0];
      wr(ADDR_SUPPLY, {24'h0, s[4], 1'b0, s[3:2], 2'b00, s[1:0]});
      repeat (24) @(posedge clk_sys);
      check({ladderEn, pumpEn}, {~s[4], s[4]});
      check(32'(biasDen), 32'h3);
      if (s[4]) begin
        check(32'(halfPeriod), 32'h1 << s[3:2]);
      end else begin
        check({pumpClk, ladderHigh}, {1'b0, s[3]});
      end
      d = (s[1:0] == 2'h2) ? 32'h0 : (s[1:0] == 2'h3) ? 32'h4 : 32'h1 << s[1:0];
      check({topExt, topInt, midInt}, d);
    end
    // Alternate and blank against every duty setting
    for (i = 0; i < 8; i++) begin
      wr(ADDR_DUTY, i);
      wr(ADDR_BLINK, 32'h0000_0040);
      check(32'(bpCount), i + 1);
      check(32'(showAlt), 32'(i < 4));
      wr(ADDR_BLINK, 32'h0000_0060);
      check(32'(showBlank), 32'h1);
    end
    // Blink timing at four backplanes then eight
    wr(ADDR_DUTY, 32'h0000_0003);
    wr(ADDR_BLINK, 32'h0000_0080);
    half(1'b0, h);
    check(h, 32'd2048);
    wr(ADDR_BLINK, 32'h0000_0081);
    half(1'b0, h);
    check(h, 32'd4096);
    wr(ADDR_BLINK, 32'h0000_0088);
    half(1'b1, h);
    check({h[30:0], showBlank}, 32'd4096);
    wr(ADDR_DUTY, 32'h0000_0007);
    half(1'b0, h);
    check({h[30:0], showAlt}, 32'd4096);
    wr(ADDR_BLINK, 32'h0000_0000);
    half(1'b0, h);
    check(h, 32'd10000);
    check(32'(blinkPhase), 32'h0);
    // Enable low freezes the pump, still at load 3 (half period 8)
    @(posedge clk_sys);
    clkEn <= 1'b0;
    @(posedge clk_sys);
    d = 32'(pumpClk);
    repeat (8) @(posedge clk_sys);
    check(32'(pumpClk), d);
    clkEn <= 1'b1;
    end_of_test();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
endmodule // tb_top
